/* File: inc/fpx_pkg.sv */
package fpx_pkg;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;
  localparam logic [31:0] STATUS_RESET = 32'h00040001;
  localparam logic [31:0] STATUS_WMASK = 32'h003FFFFF;

  // ************************************************************
  // status/control field positions
  // ************************************************************
  localparam int ROUND_LSB = 0;
  localparam int FLAG_LSB = 2;
  localparam int EN_LSB = 7;
  localparam int CAUSE_LSB = 12;
  localparam int FLUSH_POS = 18;
  localparam int DOUBLE_POS = 19;
  localparam int SIZE_POS = 20;
  localparam int BANK_POS = 21;

  // exception bit order inside cause, enable and flag
  localparam int EXC_I = 0;
  localparam int EXC_U = 1;
  localparam int EXC_O = 2;
  localparam int EXC_Z = 3;
  localparam int EXC_V = 4;
  localparam int EXC_E = 5;

  localparam logic [1:0] ROUND_NEAREST = 2'h0;
  localparam logic [1:0] ROUND_TOWARD_ZERO = 2'h1;

  // ************************************************************
  // timing and single-precision constants
  // ************************************************************
  localparam logic [1:0] LOAD_CYCLES = 2'h3;
  localparam logic signed [9:0] EXP_INF = 10'sh0FF;
  localparam logic signed [9:0] EXP_ONE = 10'sh001;
  localparam logic [9:0] SHIFT_MAX = 10'h01A;
  localparam logic [30:0] MAG_INF = 31'h7F800000;
  localparam logic [30:0] MAG_MAXNORM = 31'h7F7FFFFF;
  localparam logic [31:0] QNAN = 32'h7FFFFFFF;

  typedef enum logic [2:0] {
    OP_ARITH,
    OP_DIVIDE,
    OP_DOT,
    OP_MATRIX,
    OP_BANK_FLIP,
    OP_SIZE_FLIP,
    OP_MOVE
  } fpx_op_t;

  typedef struct packed {
    logic [1:0] roundSel;
    logic [4:0] flag;
    logic [4:0] en;
    logic [5:0] cause;
    logic flushMode;
    logic doubleMode;
    logic sizeMode;
    logic bankMode;
    logic [1:0] loadCnt;
    logic [31:0] loadData;
    logic busy;
    logic [31:0] rdata;
    logic [31:0] result;
    logic resWrite;
    logic fpuTrap;
    logic illegalTrap;
    logic moveReq;
    logic movePair;
    logic [31:0] operand;
  } fpx_state_t;

endpackage

/* File: logic/fpx_core.sv */
module fpx_core
  import fpx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [fpx_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // instruction issue from the core
  input wire logic issueValid,
  input wire fpx_pkg::fpx_op_t issueOp,
  input wire logic fpuOffBit,
  input wire logic [31:0] operandIn,
  input wire logic invalidIn,
  input wire logic divZeroIn,
  input wire logic mayOverflow,
  input wire logic mayUnderflow,
  input wire logic mayInexact,
  // unrounded value: biased exponent, 1.23 mantissa, round bit, sticky bit
  input wire logic unrSign,
  input wire logic signed [9:0] unrExp,
  input wire logic [25:0] unrMant,
  // results to the core
  output logic [31:0] resData,
  output logic resWrite,
  output logic fpuTrap,
  output logic illegalTrap,
  output logic loadBusy,
  output logic [31:0] operandOut,
  output logic moveReq,
  output logic movePair,
  output logic bankSel,
  output logic sizeBit
);
  import fpx_pkg::*;

  fpx_state_t st_ff;
  fpx_state_t nxt_st;

  logic go;
  logic isMath;
  logic [31:0] statusWord;
  logic denormIn;
  logic tiny;
  logic [9:0] shAmt;
  logic signed [10:0] shDiff;
  logic [51:0] ext;
  logic [25:0] mAdj;
  logic stk;
  logic inx;
  logic inc;
  logic [7:0] expF;
  logic [31:0] sum;
  logic zeroIn;
  logic ovf;
  logic unf;
  logic [31:0] rounded;
  logic [5:0] cause;
  logic trap;

  // ************************************************************
  // rounding datapath
  // ************************************************************
  always_comb begin
    zeroIn = !unrMant[25];
    tiny = unrExp < EXP_ONE;
    shDiff = 11'(EXP_ONE) - 11'(unrExp);
    // deep underflow collapses into the sticky bit
    if (!tiny) begin
      shAmt = 10'h000;
    end else if (shDiff > 11'(SHIFT_MAX)) begin
      shAmt = SHIFT_MAX;
    end else begin
      shAmt = shDiff[9:0];
    end
    ext = {unrMant, 26'h0} >> shAmt;
    mAdj = ext[51:26];
    stk = (|ext[25:0]) | mAdj[0];
    inx = !zeroIn && (mAdj[1] || stk);
    // nearest: up when above half, or at half with odd lsb
    inc = (st_ff.roundSel == ROUND_NEAREST) && mAdj[1] && (stk || mAdj[2]);
    // toward zero never increments, so only dropping digits remains
    expF = tiny ? 8'h00 : unrExp[7:0];
    // a carry out of the fraction walks into the exponent
    sum = {1'b0, expF, mAdj[24:2]} + {31'h0, inc};
    ovf = !zeroIn && ((unrExp >= EXP_INF) || (sum[30:23] == 8'hFF));
    unf = !zeroIn && tiny && inx;
    if (zeroIn) begin
      rounded = {unrSign, 31'h0};
    end else if (ovf && st_ff.roundSel == ROUND_NEAREST) begin
      rounded = {unrSign, MAG_INF};
    end else if (ovf) begin
      rounded = {unrSign, MAG_MAXNORM};
    end else if (unf && st_ff.flushMode) begin
      rounded = {unrSign, 31'h0};
    end else begin
      rounded = {unrSign, sum[30:0]};
    end
  end

  // ************************************************************
  // exception sources and trap decision
  // ************************************************************
  always_comb begin
    go = issueValid && !st_ff.busy;
    isMath = issueOp inside {OP_ARITH, OP_DIVIDE, OP_DOT, OP_MATRIX};
    denormIn = (operandIn[30:23] == 8'h00) && (|operandIn[22:0]);
    cause = 6'h00;
    cause[EXC_E] = denormIn && !st_ff.flushMode;
    cause[EXC_V] = invalidIn;
    cause[EXC_Z] = divZeroIn && issueOp == OP_DIVIDE;
    cause[EXC_O] = ovf;
    cause[EXC_U] = unf;
    // approximate geometry never claims an exact result
    cause[EXC_I] = inx || ovf || unf || issueOp inside {OP_DOT, OP_MATRIX};
    // matrix transform cannot pre-check every element, so V enable alone traps
    trap = cause[EXC_E]
      || (st_ff.en[EXC_V] && (issueOp == OP_MATRIX || invalidIn))
      || (st_ff.en[EXC_Z] && cause[EXC_Z])
      || (st_ff.en[EXC_O] && mayOverflow)
      || (st_ff.en[EXC_U] && mayUnderflow)
      || (st_ff.en[EXC_I] && (mayInexact || cause[EXC_I]));
    statusWord = {10'h000, st_ff.bankMode, st_ff.sizeMode, st_ff.doubleMode, st_ff.flushMode,
      st_ff.cause, st_ff.en, st_ff.flag, st_ff.roundSel};
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 32'h0;
    nxt_st.resWrite = 1'b0;
    nxt_st.fpuTrap = 1'b0;
    nxt_st.illegalTrap = 1'b0;
    nxt_st.moveReq = 1'b0;
    // denormal passes on as signed zero when flushing
    nxt_st.operand = (st_ff.flushMode && denormIn) ? {operandIn[31], 31'h0} : operandIn;
    if (regRd && regAddr == STATUS_OFS) begin
      nxt_st.rdata = statusWord;
    end
    if (go && fpuOffBit) begin
      nxt_st.illegalTrap = 1'b1;
    end else if (go) begin
      unique case (issueOp)
        OP_ARITH, OP_DIVIDE, OP_DOT, OP_MATRIX: begin
          nxt_st.cause = cause;
          nxt_st.flag = st_ff.flag | cause[4:0];
          nxt_st.fpuTrap = trap;
          nxt_st.resWrite = !trap;
          if (invalidIn) begin
            nxt_st.result = QNAN;
          end else if (cause[EXC_Z]) begin
            nxt_st.result = {unrSign, MAG_INF};
          end else begin
            nxt_st.result = rounded;
          end
        end
        OP_BANK_FLIP: begin
          nxt_st.bankMode = !st_ff.bankMode;
        end
        OP_SIZE_FLIP: begin
          nxt_st.sizeMode = !st_ff.sizeMode;
        end
        OP_MOVE: begin
          nxt_st.moveReq = 1'b1;
          nxt_st.movePair = st_ff.sizeMode;
        end
      endcase
    end
    // full register load holds off issue while the unit settles
    if (st_ff.loadCnt == 2'h1) begin
      nxt_st.roundSel = st_ff.loadData[ROUND_LSB+:2];
      nxt_st.flag = st_ff.loadData[FLAG_LSB+:5];
      nxt_st.en = st_ff.loadData[EN_LSB+:5];
      nxt_st.cause = st_ff.loadData[CAUSE_LSB+:6];
      nxt_st.flushMode = st_ff.loadData[FLUSH_POS];
      nxt_st.doubleMode = st_ff.loadData[DOUBLE_POS];
      nxt_st.sizeMode = st_ff.loadData[SIZE_POS];
      nxt_st.bankMode = st_ff.loadData[BANK_POS];
    end
    if (st_ff.loadCnt != 2'h0) begin
      nxt_st.loadCnt = st_ff.loadCnt - 2'h1;
    end
    if (regWr && regAddr == STATUS_OFS) begin
      nxt_st.loadCnt = LOAD_CYCLES;
      nxt_st.loadData = regWdata & STATUS_WMASK;
    end
    nxt_st.busy = nxt_st.loadCnt != 2'h0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{roundSel: STATUS_RESET[ROUND_LSB+:2], flushMode: STATUS_RESET[FLUSH_POS],
        default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdata = st_ff.rdata;
  assign resData = st_ff.result;
  assign resWrite = st_ff.resWrite;
  assign fpuTrap = st_ff.fpuTrap;
  assign illegalTrap = st_ff.illegalTrap;
  assign loadBusy = st_ff.busy;
  assign operandOut = st_ff.operand;
  assign moveReq = st_ff.moveReq;
  assign movePair = st_ff.movePair;
  assign bankSel = st_ff.bankMode;
  assign sizeBit = st_ff.sizeMode;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FPU_OFF: assert property (
    go && fpuOffBit |=> illegalTrap && !fpuTrap && !resWrite)
    else $error("fpu off did not give illegal instruction");
  AST_ERR_TRAP: assert property (
    go && !fpuOffBit && isMath && denormIn && !st_ff.flushMode |=> fpuTrap && st_ff.cause[EXC_E])
    else $error("denormal input did not trap");
  AST_FLAG_STICKY: assert property (
    st_ff.loadCnt != 2'h1 |=> ($past(st_ff.flag) & ~st_ff.flag) == 5'h00)
    else $error("flag bit cleared by hardware");
  AST_GEOM_INEXACT: assert property (
    go && !fpuOffBit && issueOp inside {OP_DOT, OP_MATRIX}
      |=> st_ff.cause[EXC_I] && st_ff.flag[EXC_I])
    else $error("geometry op did not set inexact");
  AST_TRAP_NO_WRITE: assert property (
    fpuTrap |-> !resWrite)
    else $error("destination written on trap");
  AST_BANK_FLIP: assert property (
    go && !fpuOffBit && issueOp == OP_BANK_FLIP && st_ff.loadCnt != 2'h1
      |=> bankSel != $past(bankSel))
    else $error("bank bit not inverted");
  AST_SIZE_FLIP: assert property (
    go && !fpuOffBit && issueOp == OP_SIZE_FLIP && st_ff.loadCnt != 2'h1
      |=> sizeBit != $past(sizeBit))
    else $error("size bit not inverted");
  AST_LOAD_TIME: assert property (
    regWr && regAddr == STATUS_OFS ##1 (!regWr)[*3]
      |=> statusWord == ($past(regWdata, 4) & STATUS_WMASK))
    else $error("status load not complete after four cycles");
  AST_ZERO_CLAMP: assert property (
    go && !fpuOffBit && issueOp == OP_ARITH && st_ff.roundSel == ROUND_TOWARD_ZERO && ovf
      && !trap && !invalidIn |=> resData == {$past(unrSign), MAG_MAXNORM})
    else $error("toward zero overflow not clamped");
  AST_MATRIX_V: assert property (
    go && !fpuOffBit && issueOp == OP_MATRIX && st_ff.en[EXC_V] |=> fpuTrap)
    else $error("matrix transform did not trap on invalid enable");

  COV_DOT_TRAP: cover property (go && issueOp == OP_DOT ##1 fpuTrap);
  COV_LOAD: cover property (regWr ##4 !loadBusy);
  COV_OVF_NEAREST: cover property (go && ovf && st_ff.roundSel == ROUND_NEAREST ##1 resWrite);
  COV_PAIR_MOVE: cover property (moveReq && movePair);

endmodule // fpx_core

/* File: sim/fpx_cpu_model.sv */
// ************************************************************
// core side: issues at most one float instruction per call
// ************************************************************
module fpx_cpu_model
  import fpx_pkg::*;
#(
  parameter bit BIG_END = 1'b1
) (
  // clock and mode
  input wire logic clk,
  input wire logic sizeBit,
  // issue
  output logic issueValid,
  output fpx_pkg::fpx_op_t issueOp,
  output logic fpuOffBit,
  output logic [31:0] operandIn,
  output logic invalidIn,
  output logic divZeroIn,
  output logic [2:0] mayOUI,
  output logic unrSign,
  output logic signed [9:0] unrExp,
  output logic [25:0] unrMant
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    issueValid = 1'b0;
    issueOp = OP_ARITH;
    {fpuOffBit, invalidIn, divZeroIn, mayOUI, unrSign} = '0;
    operandIn = 32'h0;
    unrExp = 10'sh000;
    unrMant = 26'h0;
  end
  // fl = {off, invalid, divzero, mayO, mayU, mayI}
  task automatic issue(input fpx_op_t op, input logic [31:0] o, input logic [5:0] fl,
                       input logic s, input logic signed [9:0] e, input logic [25:0] m);
    // little endian: a move while sizeBit is set is dropped, nothing is issued
    if (op == OP_MOVE && sizeBit && !BIG_END) return;
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= op;
    {fpuOffBit, invalidIn, divZeroIn, mayOUI} <= fl;
    operandIn <= o;
    unrSign <= s;
    unrExp <= e;
    unrMant <= m;
    @(posedge clk);
    issueValid <= 1'b0;
    // released operandIn and unrMant lines must not keep a stale value
    operandIn <= ~o;
    unrMant <= ~m;
  endtask
endmodule // fpx_cpu_model

/* File: sim/tb_fpx_core.sv */
module tb_fpx_core;
  timeunit 1ns;
  timeprecision 1ps;
  import fpx_pkg::*;
  localparam logic [31:0] ONE = 32'h3F800000;
  logic clk, sys_rst, regWr, regRd, issueValid, fpuOffBit, invalidIn, divZeroIn, unrSign;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, operandIn, resData, operandOut, v;
  logic [2:0] mayOUI;
  logic signed [9:0] unrExp;
  logic [25:0] unrMant;
  logic resWrite, fpuTrap, illegalTrap, loadBusy, moveReq, movePair, bankSel, sizeBit;
  fpx_op_t issueOp;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  fpx_core i_fpx_core (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .issueValid(issueValid),
    .issueOp(issueOp), .fpuOffBit(fpuOffBit), .operandIn(operandIn), .invalidIn(invalidIn),
    .divZeroIn(divZeroIn), .mayOverflow(mayOUI[2]), .mayUnderflow(mayOUI[1]),
    .mayInexact(mayOUI[0]), .unrSign(unrSign), .unrExp(unrExp), .unrMant(unrMant),
    .resData(resData), .resWrite(resWrite), .fpuTrap(fpuTrap), .illegalTrap(illegalTrap),
    .loadBusy(loadBusy), .operandOut(operandOut), .moveReq(moveReq), .movePair(movePair),
    .bankSel(bankSel), .sizeBit(sizeBit));
  fpx_cpu_model i_fpx_cpu_model (.clk(clk), .sizeBit(sizeBit), .issueValid(issueValid),
    .issueOp(issueOp), .fpuOffBit(fpuOffBit), .operandIn(operandIn), .invalidIn(invalidIn),
    .divZeroIn(divZeroIn), .mayOUI(mayOUI), .unrSign(unrSign), .unrExp(unrExp),
    .unrMant(unrMant));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] st(logic [5:0] c, logic [4:0] f, logic [4:0] en,
                                     logic [1:0] rm, logic dn);
    return (32'(c) << CAUSE_LSB) | (32'(f) << FLAG_LSB) | (32'(en) << EN_LSB) | 32'(rm)
      | (32'(dn) << FLUSH_POS);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    if (d[SIZE_POS]) d[DOUBLE_POS] = 1'b0;
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic cfg(input logic [31:0] d);
    wr(STATUS_OFS, d);
    #1 check("busy", loadBusy, 1);
    repeat (4) @(posedge clk);
  endtask
  task automatic rs(input logic [31:0] exp);
    rd(STATUS_OFS, v);
    check("status", v, exp);
  endtask
  task automatic ex(input fpx_op_t op, input logic [5:0] fl, input logic s,
                    input logic signed [9:0] e, input logic [25:0] m, input logic [31:0] o = ONE);
    i_fpx_cpu_model.issue(op, o, fl, s, e, m);
    #1;
  endtask
  task automatic res_chk(input logic [31:0] exp);
    check("result", resData, exp);
    check("write", resWrite, 1);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {sys_rst, regWr, regRd, regAddr, regWdata} = {1'b1, 38'h0};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rs(STATUS_RESET);
    check("bank", bankSel, 0);
    rd(4'h4, v);
    check("unmapped", v, 0);
    cfg(32'hFFFFFFFF);
    rs(32'h0037FFFF);
    check("bank", bankSel, 1);
    wr(STATUS_OFS, st(0, 0, 0, ROUND_NEAREST, 0));
    ex(OP_BANK_FLIP, 0, 0, 0, 0);
    check("drop", bankSel, 1);
    repeat (4) @(posedge clk);
    check("bank", bankSel, 0);
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000006);
    res_chk(32'h3F800002);
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000002);
    res_chk(32'h3F800000);
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000003);
    res_chk(32'h3F800001);
    ex(OP_ARITH, 6'h04, 1, 10'sh0FE, 26'h3FFFFFE);
    res_chk(32'hFF800000);
    rs(st(6'h05, 5'h05, 0, ROUND_NEAREST, 0));
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000000);
    rs(st(6'h00, 5'h05, 0, ROUND_NEAREST, 0));
    ex(OP_ARITH, 6'h00, 0, 10'sh000, 26'h2000000);
    res_chk(32'h00400000);
    cfg(st(0, 0, 0, ROUND_TOWARD_ZERO, 0));
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000007);
    res_chk(32'h3F800001);
    ex(OP_ARITH, 6'h04, 1, 10'sh0FF, 26'h2000000);
    res_chk(32'hFF7FFFFF);
    ex(OP_DIVIDE, 6'h08, 1, 10'sh07F, 26'h2000000);
    res_chk(32'hFF800000);
    ex(OP_ARITH, 6'h10, 0, 10'sh07F, 26'h2000000);
    res_chk(QNAN);
    rs(st(6'h10, 5'h1D, 0, ROUND_TOWARD_ZERO, 0));
    // traps: enables for invalid, divide and overflow
    cfg(st(0, 0, 5'h1C, ROUND_NEAREST, 0));
    ex(OP_DIVIDE, 6'h08, 0, 10'sh07F, 26'h2000000);
    check("trap", fpuTrap, 1);
    check("write", resWrite, 0);
    ex(OP_MATRIX, 6'h00, 0, 10'sh07F, 26'h2000000);
    check("trap", fpuTrap, 1);
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000000);
    check("trap", fpuTrap, 0);
    ex(OP_ARITH, 6'h04, 0, 10'sh07F, 26'h2000000);
    check("trap", fpuTrap, 1);
    cfg(st(0, 0, 5'h01, ROUND_NEAREST, 0));
    ex(OP_DOT, 6'h00, 0, 10'sh07F, 26'h2000000);
    check("trap", fpuTrap, 1);
    rs(st(6'h01, 5'h01, 5'h01, ROUND_NEAREST, 0));
    cfg(st(0, 0, 0, ROUND_NEAREST, 0));
    ex(OP_ARITH, 6'h00, 0, 10'sh07F, 26'h2000000, 32'h80000001);
    check("trap", fpuTrap, 1);
    rs(st(6'h20, 5'h00, 0, ROUND_NEAREST, 0));
    cfg(st(0, 0, 0, ROUND_NEAREST, 1));
    ex(OP_ARITH, 6'h00, 1, 10'sh000, 26'h2000001, 32'h80000001);
    check("trap", fpuTrap, 0);
    check("flush", operandOut, 32'h80000000);
    res_chk(32'h80000000);
    ex(OP_BANK_FLIP, 6'h20, 0, 0, 0);
    check("illegal", illegalTrap, 1);
    check("bank", bankSel, 0);
    ex(OP_BANK_FLIP, 6'h00, 0, 0, 0);
    check("bank", bankSel, 1);
    ex(OP_SIZE_FLIP, 6'h00, 0, 0, 0);
    check("size", sizeBit, 1);
    ex(OP_MOVE, 6'h00, 0, 0, 0);
    check("pair", {moveReq, movePair}, 2'h3);
    ex(OP_SIZE_FLIP, 6'h00, 0, 0, 0);
    ex(OP_MOVE, 6'h00, 0, 0, 0);
    check("pair", {moveReq, movePair, sizeBit}, 3'h4);
    end_sim();
  end
endmodule // tb_fpx_core
